// File: logic/bsb_pkg.sv
package bsb_pkg;

  // ******************************************************
  // register map (byte addresses on the apb)
  // ******************************************************
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_INSTR    = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_PC       = 12'h008;
  localparam logic [3:0]  WIN_REGS      = 4'h1;
  localparam logic [3:0]  WIN_IO        = 4'h2;
  localparam int          NUM_REGS      = 32;
  localparam int          NUM_IO        = 32;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [7:0]  DATA_RESET    = 8'h00;

  // ******************************************************
  // status register bit positions
  // ******************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ******************************************************
  // operations and instruction word
  // ******************************************************
  typedef enum logic [4:0] {
    OP_NOP                       = 5'h00,
    OP_BRANCH_ON_COPY_FLAG_CLEAR = 5'h01,
    OP_BRANCH_ON_OVERFLOW_SET    = 5'h02,
    OP_BRANCH_ON_OVERFLOW_CLEAR  = 5'h03,
    OP_BRANCH_ON_IRQ_ENABLED     = 5'h04,
    OP_BRANCH_ON_IRQ_DISABLED    = 5'h05,
    OP_IO_BIT_SET                = 5'h06,
    OP_IO_BIT_CLEAR              = 5'h07,
    OP_SKIP_IF_IO_BIT_HIGH       = 5'h08,
    OP_SKIP_IF_IO_BIT_LOW        = 5'h09,
    OP_SHIFT_LEFT_LOGICAL        = 5'h0a,
    OP_SHIFT_RIGHT_LOGICAL       = 5'h0b,
    OP_ROTATE_LEFT_VIA_CARRY     = 5'h0c,
    OP_ROTATE_RIGHT_VIA_CARRY    = 5'h0d,
    OP_SHIFT_RIGHT_SIGNED        = 5'h0e,
    OP_NIBBLE_SWAP               = 5'h0f,
    OP_FLAG_SET                  = 5'h10,
    OP_FLAG_CLEAR                = 5'h11,
    OP_REGISTER_BIT_TO_FLAG_COPY = 5'h12,
    OP_FLAG_TO_REGISTER_BIT_COPY = 5'h13
  } bsb_op_t;

  // index is five bits wide: short forms cannot leave the base i/o space
  typedef struct packed {
    logic [7:0] offset;
    logic [2:0] flagSel;
    logic [4:0] index;
    logic [2:0] bitSel;
    bsb_op_t    op;
  } bsb_instr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_HOLD = 2'b10
  } bsb_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } bsb_apb_req_t;

endpackage

// File: logic/bsb_exec.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// RULE1: copy flag clear branches, one or two cycles
// RULE2: overflow set or clear branches, one/two cycles
// RULE3: interrupt enabled or disabled branches, one/two cycles
// RULE4: io bit set, flags kept, two cycles
// RULE5: io bit clear, flags kept, two cycles
// RULE6: rotate left through carry, flags ZCNV updated
// RULE7: rotate right through carry, flags ZCNV updated
// RULE8: register bit into copy flag only
// RULE9: copy flag into register bit, flags kept
// RULE10: short io forms reach base space only
// RULE11: nibble swap; single flag set and clear
// RULE12: logical and signed shifts update ZCNV
module bsb_exec
  import bsb_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // apb slave
  input  wire bsb_pkg::bsb_apb_req_t apbReq,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // core state
  output logic [15:0]                pc,
  output logic [7:0]                 statusFlags,
  output logic                       busy,
  output logic                       retired
);
  import bsb_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ******************************************************
  // state
  // ******************************************************
  logic [7:0]  regs   [NUM_REGS];
  logic [7:0]  ioRegs [NUM_IO];
  bsb_instr_t  instr;
  bsb_state_t  state;
  logic [7:0]  flags;

  function automatic logic [7:0] shiftFlags(input logic [7:0] f,
                                            input logic [7:0] res,
                                            input logic       c);
    logic [7:0] n;
    n         = f;
    n[FLAG_C] = c;
    n[FLAG_Z] = (res == 8'h00);
    n[FLAG_N] = res[7];
    n[FLAG_V] = res[7] ^ c;
    return n;
  endfunction

  // ******************************************************
  // apb decode
  // ******************************************************
  wire        access    = apbReq.psel & apbReq.penable;
  wire        setup     = apbReq.psel & ~apbReq.penable;
  wire [3:0]  window    = apbReq.paddr[11:8];
  wire [5:0]  wordIdx   = apbReq.paddr[7:2];
  wire        aligned   = apbReq.paddr[1:0] == 2'b00;
  wire        hitInstr  = apbReq.paddr == ADDR_INSTR;
  wire        hitStatus = apbReq.paddr == ADDR_STATUS;
  wire        hitPc     = apbReq.paddr == ADDR_PC;
  wire        hitReg    = aligned && window == WIN_REGS
                          && wordIdx < 6'(NUM_REGS);
  // anything past the base io window is refused
  wire        hitIo     = aligned && window == WIN_IO
                          && wordIdx < 6'(NUM_IO); // RULE10
  wire        mapped    = hitInstr | hitStatus | hitPc | hitReg | hitIo;
  wire [4:0]  slot      = wordIdx[4:0];
  // writes stall while busy, so the register files have one writer
  wire        stall     = busy & apbReq.psel & apbReq.pwrite;
  wire        wrFire    = access & apbReq.pwrite & pready & mapped;
  wire [31:0] rdMux     = hitInstr  ? {7'h00, busy, instr}
                        : hitStatus ? {24'h000000, flags}
                        : hitPc     ? {16'h0000, pc}
                        : hitReg    ? {24'h000000, regs[slot]}
                        : hitIo     ? {24'h000000, ioRegs[slot]}
                        : 32'h00000000;

  assign pready      = ~stall;
  assign pslverr     = access & ~mapped;
  assign busy        = state != ST_IDLE;
  assign statusFlags = flags;

  // ******************************************************
  // execute datapath
  // ******************************************************
  wire [7:0]  rd      = regs[instr.index];
  wire [7:0]  io      = ioRegs[instr.index];
  wire [7:0]  bitMask = 8'h01 << instr.bitSel;
  wire        carry   = flags[FLAG_C];

  logic [7:0] res;
  logic [7:0] ioRes;
  logic [7:0] newFlags;
  logic       shOut;
  logic       isShift;
  logic       writeReg;
  logic       writeIo;
  logic       jump;
  logic       skip;

  always_comb begin
    res      = rd;
    ioRes    = io;
    newFlags = flags;
    shOut    = carry;
    isShift  = 1'b0;
    writeReg = 1'b0;
    writeIo  = 1'b0;
    jump     = 1'b0;
    skip     = 1'b0;
    case (instr.op)
      OP_BRANCH_ON_COPY_FLAG_CLEAR: jump = ~flags[FLAG_T]; // RULE1
      OP_BRANCH_ON_OVERFLOW_SET:    jump = flags[FLAG_V];  // RULE2
      OP_BRANCH_ON_OVERFLOW_CLEAR:  jump = ~flags[FLAG_V]; // RULE2
      OP_BRANCH_ON_IRQ_ENABLED:     jump = flags[FLAG_I];  // RULE3
      OP_BRANCH_ON_IRQ_DISABLED:    jump = ~flags[FLAG_I]; // RULE3
      OP_IO_BIT_SET: begin
        writeIo = 1'b1;
        ioRes   = io | bitMask; // RULE4
      end
      OP_IO_BIT_CLEAR: begin
        writeIo = 1'b1;
        ioRes   = io & ~bitMask; // RULE5
      end
      OP_SKIP_IF_IO_BIT_HIGH: skip = io[instr.bitSel]; // RULE10
      OP_SKIP_IF_IO_BIT_LOW:  skip = ~io[instr.bitSel]; // RULE10
      OP_SHIFT_LEFT_LOGICAL: begin
        {shOut, res} = {rd, 1'b0}; // RULE12
        isShift      = 1'b1;
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        {res, shOut} = {1'b0, rd}; // RULE12
        isShift      = 1'b1;
      end
      OP_SHIFT_RIGHT_SIGNED: begin
        {res, shOut} = {rd[7], rd}; // RULE12
        isShift      = 1'b1;
      end
      OP_ROTATE_LEFT_VIA_CARRY: begin
        {shOut, res} = {rd, carry}; // RULE6
        isShift      = 1'b1;
      end
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        {res, shOut} = {carry, rd}; // RULE7
        isShift      = 1'b1;
      end
      OP_NIBBLE_SWAP: begin
        res      = {rd[3:0], rd[7:4]}; // RULE11
        writeReg = 1'b1;
      end
      OP_FLAG_SET:   newFlags[instr.flagSel] = 1'b1; // RULE11
      OP_FLAG_CLEAR: newFlags[instr.flagSel] = 1'b0; // RULE11
      OP_REGISTER_BIT_TO_FLAG_COPY:
        newFlags[FLAG_T] = rd[instr.bitSel]; // RULE8
      OP_FLAG_TO_REGISTER_BIT_COPY: begin
        res[instr.bitSel] = flags[FLAG_T]; // RULE9
        writeReg          = 1'b1;
      end
      default: ;
    endcase
    if (isShift) begin
      writeReg = 1'b1;
      newFlags = shiftFlags(flags, res, shOut);
    end
  end

  // skip assumes the next instruction is one word long
  wire [15:0] offExt    = {{8{instr.offset[7]}}, instr.offset};
  wire [15:0] target    = pc + offExt + 16'h0001;
  wire [15:0] next_pc   = jump ? target
                        : skip ? pc + 16'h0002
                        : pc + 16'h0001;
  wire        twoCycle  = jump | skip
                        | instr.op == OP_IO_BIT_SET
                        | instr.op == OP_IO_BIT_CLEAR; // RULE4 RULE5
  wire        execNow   = state == ST_EXEC;

  // ******************************************************
  // sequencer
  // ******************************************************
  bsb_state_t next_state;
  assign next_state = (state == ST_IDLE && wrFire && hitInstr) ? ST_EXEC
                    : (execNow && twoCycle)                  ? ST_HOLD
                    : (execNow || state == ST_HOLD)          ? ST_IDLE
                    : state;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state   <= ST_IDLE;
      retired <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      state   <= next_state;
      retired <= (execNow & ~twoCycle) | (state == ST_HOLD);
      if (setup) begin
        prdata <= rdMux;
      end
    end
  end

  // ******************************************************
  // architectural registers
  // ******************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pc    <= PC_RESET;
      flags <= STATUS_RESET;
      instr <= '0;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= DATA_RESET;
      end
      for (int i = 0; i < NUM_IO; i++) begin
        ioRegs[i] <= DATA_RESET;
      end
    end else if (execNow) begin
      pc    <= next_pc; // RULE1 RULE2 RULE3
      flags <= newFlags;
      if (writeReg) begin
        regs[instr.index] <= res;
      end
      if (writeIo) begin
        ioRegs[instr.index] <= ioRes;
      end
    end else if (wrFire) begin
      if (hitInstr) begin
        instr <= bsb_instr_t'(apbReq.pwdata[23:0]);
      end
      if (hitStatus) begin
        flags <= apbReq.pwdata[7:0];
      end
      if (hitPc) begin
        pc <= apbReq.pwdata[15:0];
      end
      if (hitReg) begin
        regs[slot] <= apbReq.pwdata[7:0];
      end
      if (hitIo) begin
        ioRegs[slot] <= apbReq.pwdata[7:0];
      end
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  logic [7:0]  lastRd;
  logic [7:0]  lastFlags;
  logic [15:0] lastPc;
  logic [15:0] lastTarget;

  always_ff @(posedge ref_clk) begin
    lastRd     <= rd;
    lastFlags  <= flags;
    lastPc     <= pc;
    lastTarget <= target;
  end

  wire opIs = execNow;

  chk_copy_branch: assert property ( // RULE1
    opIs && instr.op == OP_BRANCH_ON_COPY_FLAG_CLEAR && !flags[FLAG_T]
    |=> pc == lastTarget && state == ST_HOLD ##1 state == ST_IDLE)
    else $error("taken copy flag branch wrong target or length");

  chk_overflow_branch: assert property ( // RULE2
    opIs && instr.op == OP_BRANCH_ON_OVERFLOW_SET && !flags[FLAG_V]
    |=> pc == lastPc + 16'h0001 && state == ST_IDLE && retired)
    else $error("untaken overflow branch not one cycle");

  chk_irq_branch: assert property ( // RULE3
    opIs && instr.op == OP_BRANCH_ON_IRQ_ENABLED && flags[FLAG_I]
    |=> pc == lastTarget ##1 retired && !busy)
    else $error("taken irq branch wrong");

  chk_io_set: assert property ( // RULE4
    opIs && instr.op == OP_IO_BIT_SET
    |=> ioRegs[instr.index][instr.bitSel] && flags == lastFlags
        && busy ##1 retired)
    else $error("io bit set wrong");

  chk_io_clear: assert property ( // RULE5
    opIs && instr.op == OP_IO_BIT_CLEAR
    |=> !ioRegs[instr.index][instr.bitSel] && flags == lastFlags
        ##1 !busy)
    else $error("io bit clear wrong");

  chk_rotate_left: assert property ( // RULE6
    opIs && instr.op == OP_ROTATE_LEFT_VIA_CARRY
    |=> regs[instr.index] == {lastRd[6:0], lastFlags[FLAG_C]}
        && flags[FLAG_C] == lastRd[7] && !busy)
    else $error("rotate left wrong");

  chk_rotate_right: assert property ( // RULE7
    opIs && instr.op == OP_ROTATE_RIGHT_VIA_CARRY
    |=> regs[instr.index] == {lastFlags[FLAG_C], lastRd[7:1]}
        && flags[FLAG_C] == lastRd[0]
        && flags[FLAG_V] == (lastFlags[FLAG_C] ^ lastRd[0]))
    else $error("rotate right wrong");

  chk_bit_to_flag: assert property ( // RULE8
    opIs && instr.op == OP_REGISTER_BIT_TO_FLAG_COPY
    |=> flags[FLAG_T] == lastRd[instr.bitSel]
        && flags[5:0] == lastFlags[5:0] && flags[7] == lastFlags[7])
    else $error("register bit to flag copy wrong");

  chk_flag_to_bit: assert property ( // RULE9
    opIs && instr.op == OP_FLAG_TO_REGISTER_BIT_COPY
    |=> regs[instr.index][instr.bitSel] == lastFlags[FLAG_T]
        && flags == lastFlags)
    else $error("flag to register bit copy wrong");

  chk_io_window: assert property ( // RULE10
    access && window == WIN_IO && wordIdx >= 6'(NUM_IO) |-> pslverr)
    else $error("extended io reached through short window");

  chk_nibble_swap: assert property ( // RULE11
    opIs && instr.op == OP_NIBBLE_SWAP
    |=> regs[instr.index] == {lastRd[3:0], lastRd[7:4]}
        && flags == lastFlags)
    else $error("nibble swap wrong");

  chk_shift_left: assert property ( // RULE12
    opIs && instr.op == OP_SHIFT_LEFT_LOGICAL
    |=> regs[instr.index] == {lastRd[6:0], 1'b0}
        && flags[FLAG_C] == lastRd[7]
        && flags[FLAG_Z] == (lastRd[6:0] == 7'h00))
    else $error("shift left wrong");

endmodule
`default_nettype wire

// File: verif/tb_bsb_exec.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    nCompared++; \
    if ((g) !== (e)) begin \
      errTotal++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_bsb_exec;
  import bsb_pkg::*;
  logic         ref_clk;
  logic         rst;
  bsb_apb_req_t req;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [15:0]  pc;
  logic [7:0]   statusFlags;
  logic         busy;
  logic         retired;
  int           errTotal;
  int           nCompared;
  int           cyc = 0;
  logic         held;
  logic [31:0]  rd;
  logic         er;
  logic [15:0]  p0;
  logic [8:0]   e;
  logic [7:0]   k;
  logic [7:0]   v;
  logic [7:0]   sf;
  logic         fl;
  logic         tk;
  logic         ci;

  bsb_exec dut_u (
    .ref_clk(ref_clk), .rst(rst), .apbReq(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pc(pc),
    .statusFlags(statusFlags), .busy(busy), .retired(retired));

  // ******************************************************
  // bus and instruction tasks
  // ******************************************************
  task automatic completeRun();
    if (errTotal == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // keep leaves psel up so the next setup follows with no idle cycle
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic keep);
    int n;
    if (!held) @(posedge ref_clk);
    req.psel   <= 1'b1;
    req.pwrite <= wr;
    req.paddr  <= a;
    req.pwdata <= d;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    `CHK("pready", 1'b1, pready)
    rd = prdata;
    er = pslverr;
    req.penable <= 1'b0;
    if (!keep) req.psel <= 1'b0;
    held = keep;
  endtask

  function automatic logic [31:0] mk(input bsb_op_t o, input logic [2:0] b,
                                     input logic [4:0] ix,
                                     input logic [2:0] s,
                                     input logic [7:0] ko);
    bsb_instr_t i;
    i = '{offset: ko, flagSel: s, index: ix, bitSel: b, op: o};
    return {8'h00, i};
  endfunction

  // counts busy cycles, then expects the retire pulse
  task automatic done(input int cy);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (busy === 1'b1 && n < 20) begin
      n++;
      @(posedge ref_clk);
    end
    `CHK("cycles", cy, n)
    `CHK("retired", 1'b1, retired)
  endtask

  task automatic run(input bsb_op_t o, input logic [2:0] b,
                     input logic [4:0] ix, input logic [2:0] s,
                     input logic [7:0] ko, input int cy);
    xfer(1'b1, ADDR_INSTR, mk(o, b, ix, s, ko), 1'b0);
    done(cy);
  endtask

  task automatic setStatus(input logic [7:0] x);
    for (int j = 0; j < 8; j++) begin
      run(x[j] ? OP_FLAG_SET : OP_FLAG_CLEAR, 3'd0, 5'd0, 3'(j), 8'h00, 1);
    end
    sf = x;
    `CHK("status", x, statusFlags)
  endtask

  function automatic logic [8:0] shx(input int o, input logic [7:0] x,
                                     input logic c);
    case (o)
      10: return {x[7], x[6:0], 1'b0};
      11: return {x[0], 1'b0, x[7:1]};
      12: return {x[7], x[6:0], c};
      13: return {x[0], c, x[7:1]};
      14: return {x[0], x[7], x[7:1]};
      default: return {c, x[3:0], x[7:4]};
    endcase
  endfunction

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // a hang anywhere ends the run as a failure
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errTotal++;
      completeRun();
    end
  end

  // ******************************************************
  // test sequence
  // ******************************************************
  initial begin
    rst = 1'b1;
    req = '0;
    held = 1'b0;
    errTotal = 0;
    nCompared = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    `CHK("pc", PC_RESET, pc)
    `CHK("status", STATUS_RESET, statusFlags)
    xfer(1'b0, 12'h104, 32'h0, 1'b0);
    `CHK("reg1", {24'h0, DATA_RESET}, rd)
    `CHK("slverr", 1'b0, er)
    setStatus(8'ha5);
    setStatus(8'h5a);
    for (int o = 1; o <= 5; o++) begin
      for (int f = 0; f < 2; f++) begin
        fl = f[0];
        setStatus(fl ? 8'hc8 : 8'h00);
        tk = (o % 2 == 0) ? fl : !fl;
        k = fl ? 8'h05 : 8'hf9;
        p0 = pc;
        run(bsb_op_t'(o[4:0]), 3'd0, 5'd0, 3'd0, k, tk ? 2 : 1);
        `CHK("pc", tk ? p0 + {{8{k[7]}}, k} + 16'h1 : p0 + 16'h1, pc)
        `CHK("status", sf, statusFlags)
      end
    end
    xfer(1'b1, 12'h27c, 32'h5a, 1'b0);
    setStatus(8'h3c);
    run(OP_IO_BIT_SET, 3'd0, 5'd31, 3'd0, 8'h00, 2);
    xfer(1'b0, 12'h27c, 32'h0, 1'b0);
    `CHK("io31", 32'h5b, rd)
    run(OP_IO_BIT_CLEAR, 3'd6, 5'd31, 3'd0, 8'h00, 2);
    xfer(1'b0, 12'h27c, 32'h0, 1'b0);
    `CHK("io31", 32'h1b, rd)
    `CHK("status", 8'h3c, statusFlags)
    p0 = pc;
    run(OP_SKIP_IF_IO_BIT_HIGH, 3'd0, 5'd31, 3'd0, 8'h00, 2);
    run(OP_SKIP_IF_IO_BIT_LOW, 3'd0, 5'd31, 3'd0, 8'h00, 1);
    `CHK("pc", p0 + 16'h3, pc)
    xfer(1'b1, 12'h280, 32'hff, 1'b0);
    `CHK("slverr", 1'b1, er)
    xfer(1'b0, 12'h280, 32'h0, 1'b0);
    `CHK("rdata", 32'h0, rd)
    xfer(1'b0, 12'h102, 32'h0, 1'b0);
    `CHK("slverr", 1'b1, er)
    // second instruction write is stalled (pready low) until the two-cycle one retires
    xfer(1'b1, ADDR_INSTR, mk(OP_IO_BIT_SET, 3'd7, 5'd31, 3'd0, 8'h0), 1'b1);
    xfer(1'b1, ADDR_INSTR, mk(OP_FLAG_SET, 3'd0, 5'd0, 3'd0, 8'h0), 1'b0);
    done(1);
    xfer(1'b0, 12'h27c, 32'h0, 1'b0);
    `CHK("io31", 32'h9b, rd)
    `CHK("status", 8'h3d, statusFlags)
    for (int o = 10; o <= 15; o++) begin
      for (int j = 0; j < 3; j++) begin
        v = (j == 0) ? 8'h81 : (j == 1) ? 8'h01 : 8'h80;
        ci = ~j[0];
        xfer(1'b1, 12'h108, {24'h0, v}, 1'b0);
        setStatus({7'h78, ci});
        e = shx(o, v, ci);
        if (o != 15) sf[3:0] = {e[7] ^ e[8], e[7], e[7:0] == 8'h0, e[8]};
        run(bsb_op_t'(o[4:0]), 3'd0, 5'd2, 3'd0, 8'h00, 1);
        xfer(1'b0, 12'h108, 32'h0, 1'b0);
        `CHK("reg2", {24'h0, e[7:0]}, rd)
        `CHK("status", sf, statusFlags)
      end
    end
    xfer(1'b1, 12'h10c, 32'h20, 1'b0);
    xfer(1'b1, 12'h11c, 32'h80, 1'b0);
    setStatus(8'h00);
    run(OP_REGISTER_BIT_TO_FLAG_COPY, 3'd5, 5'd3, 3'd0, 8'h00, 1);
    `CHK("status", 8'h40, statusFlags)
    run(OP_FLAG_TO_REGISTER_BIT_COPY, 3'd0, 5'd7, 3'd0, 8'h00, 1);
    xfer(1'b0, 12'h11c, 32'h0, 1'b0);
    `CHK("reg7", 32'h81, rd)
    `CHK("status", 8'h40, statusFlags)
    run(OP_REGISTER_BIT_TO_FLAG_COPY, 3'd4, 5'd3, 3'd0, 8'h00, 1);
    `CHK("status", 8'h00, statusFlags)
    run(OP_FLAG_TO_REGISTER_BIT_COPY, 3'd7, 5'd7, 3'd0, 8'h00, 1);
    xfer(1'b0, 12'h11c, 32'h0, 1'b0);
    `CHK("reg7", 32'h01, rd)
    // instruction word layout and the status and pc windows
    xfer(1'b0, ADDR_INSTR, 32'h0, 1'b0);
    `CHK("instr", 32'h000007f3, rd)
    xfer(1'b1, ADDR_PC, 32'h1234, 1'b0);
    xfer(1'b1, ADDR_STATUS, 32'h96, 1'b0);
    xfer(1'b0, ADDR_STATUS, 32'h0, 1'b0);
    `CHK("status", 32'h96, rd)
    `CHK("status", 8'h96, statusFlags)
    xfer(1'b0, ADDR_PC, 32'h0, 1'b0);
    `CHK("pcrd", 32'h1234, rd)
    `CHK("pc", 16'h1234, pc)
    completeRun();
  end
endmodule
`default_nettype wire
